// ==== shared/lpb_params.svh ====
// constants for the low-power ddr link: widths, field positions, command codes, timing
// Notes on behaviour
// - capture command/address on both clock edges
// - sample select and clock enable on rise
// - clock enable low shuts receivers and drivers
// - clock enable transitions enter and leave power-down
// - write mask byte lanes, reads unaffected
// - per-lane strobe: aligned on reads, centered writes
// - ten-bit command/address bus
// - command spans one cycle, rise then fall
// - two data bits per pin per cycle
// - one wide core word, four pin beats
// - bursts start at column, sequential order
// - activate opens chosen row in chosen bank
// - read/write selects bank and start column
// - eight independent banks
// - controller follows power-up sequence
// - lowest column bit implied zero
`ifndef LPB_PARAMS_SVH
`define LPB_PARAMS_SVH

`define LPB_CA_W        10
`define LPB_DQ_W        32
`define LPB_LANES       4
`define LPB_BANKS       8
`define LPB_BANK_W      3
`define LPB_ROW_W       14
`define LPB_COL_W       9
`define LPB_BL          4
`define LPB_WORD_W      128
`define LPB_BEAT_W      3

// rise-half field positions; fall half carries row low bits or column bits 8..1
`define LPB_CMD_LSB     0
`define LPB_CMD_W       3
`define LPB_BANK_LSB    3
`define LPB_ROWHI_LSB   6
`define LPB_ROWHI_W     4
`define LPB_ROWLO_W     10
`define LPB_COLF_W      8

// command codes in the rise half
`define LPB_CMD_NOP     3'h0
`define LPB_CMD_ACT     3'h1
`define LPB_CMD_WR      3'h2
`define LPB_CMD_RD      3'h3
`define LPB_CMD_PRE     3'h4

// modelled storage: bank, two row bits, four column bits
`define LPB_MEM_AW      9
`define LPB_MEM_ROW_W   2

// timing
`define LPB_T_SYS_NS    40
`define LPB_T_CK_NS     320
`define LPB_CK_DIV      (`LPB_T_CK_NS / `LPB_T_SYS_NS)
`define LPB_CK_HALF     (`LPB_CK_DIV / 2)
`define LPB_PH_W        3
`define LPB_PH_RISE_SET 3'h6
`define LPB_PH_FALL_SET 3'h2
`define LPB_PH_DQ_A     3'h7
`define LPB_PH_DQ_B     3'h3
`define LPB_PH_DQS_A    3'h1
`define LPB_PH_DQS_B    3'h5

`endif

// ==== shared/lpb_pkg.sv ====
// types shared by both ends of the low-power ddr link
`default_nettype none
package lpb_pkg;
  typedef logic [2:0] lpb_cmd_t;
  typedef logic [7:0] lpb_bank_mask_t;
  typedef enum logic [2:0] {DS_PDOWN, DS_IDLE, DS_CMD, DS_READ, DS_WRITE} lpb_dev_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_CMD, HS_WDATA, HS_RDATA} lpb_host_state_t;
endpackage
`default_nettype wire

// ==== shared/lpb_if.sv ====
// link between memory controller end and memory device end
`timescale 1ns/100ps
`default_nettype none
interface lpb_if;
  logic        ck;        // link clock, made by the controller
  logic        cke;       // clock enable
  logic        cs_n;      // chip select, active low
  logic [9:0]  ca;        // command/address, both edges
  logic [3:0]  dm;        // write mask per byte lane
  logic [31:0] h_dq_o;    // controller data drive
  logic        h_dq_oe;
  logic [3:0]  h_dqs_o;   // controller strobes
  logic        h_dqs_oe;
  logic [31:0] d_dq_o;    // device data drive
  logic        d_dq_oe;
  logic [3:0]  d_dqs_o;   // device strobes
  logic        d_dqs_oe;
  logic [31:0] dq;        // resolved data wires
  logic [3:0]  dqs;       // resolved strobe wires
  // undriven wires read low
  assign dq  = h_dq_oe ? h_dq_o : (d_dq_oe ? d_dq_o : '0);
  assign dqs = h_dqs_oe ? h_dqs_o : (d_dqs_oe ? d_dqs_o : '0);
  modport host (output ck, cke, cs_n, ca, dm, h_dq_o, h_dq_oe, h_dqs_o, h_dqs_oe, input dq, dqs);
  modport dev (input ck, cke, cs_n, ca, dm, dq, dqs, output d_dq_o, d_dq_oe, d_dqs_o, d_dqs_oe);
endinterface // lpb_if
`default_nettype wire

// ==== core/lpb_sync.sv ====
// two-flop synchroniser for a bundle of pins
`timescale 1ns/100ps
`default_nettype none
module lpb_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;       // first stage, read only by second stage
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // next values are simply the previous stage
  always_comb begin
    next_meta = i_d;
    next_q    = meta;
  end

  // both stages clear on reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= next_meta;
      o_q  <= next_q;
    end
  end
endmodule // lpb_sync
`default_nettype wire

// ==== core/lpb_dev.sv ====
// memory device end: command decode, eight banks, burst read and masked write
`timescale 1ns/100ps
`default_nettype none
`include "lpb_params.svh"
module lpb_dev (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  lpb_if.dev                     bus,
  output logic                   o_power_down,
  output lpb_pkg::lpb_bank_mask_t o_bank_open
);
  import lpb_pkg::*;

  localparam int SW = 3 + `LPB_CA_W + 2 * `LPB_LANES + `LPB_DQ_W;

  // synchronised pins
  logic [SW-1:0]          pin_s;
  logic                   ck_s;
  logic                   cke_s;
  logic                   cs_n_s;
  logic [`LPB_CA_W-1:0]   ca_s;
  logic [3:0]             dm_s;
  logic [31:0]            dq_s;
  logic [3:0]             dqs_s;
  logic                   ck_rise;
  logic                   ck_fall;

  // control state
  lpb_dev_state_t         state, next_state;
  logic                   ck_p, next_ck_p;          // last sampled link clock
  logic [3:0]             dqs_p, next_dqs_p;        // last sampled strobes
  lpb_cmd_t               cmd, next_cmd;            // command held from rise half
  logic [2:0]             acc_bank, next_acc_bank;
  logic [3:0]             row_hi, next_row_hi;
  logic [7:0][13:0]       open_row, next_open_row;  // row open in each bank
  lpb_bank_mask_t         bank_open, next_bank_open;
  logic [8:0]             base, next_base;          // burst start word
  logic [127:0]           rd_word, next_rd_word;    // prefetched core word
  logic [2:0]             beat, next_beat;
  logic [3:0][2:0]        lane_beat, next_lane_beat;
  logic [3:0][31:0]       wbuf, next_wbuf;          // gathered write beats
  logic [3:0][3:0]        wmask, next_wmask;
  logic                   commit, next_commit;      // core write strobe
  logic [31:0]            dq_o, next_dq;
  logic                   dq_oe, next_dq_oe;
  logic [3:0]             dqs_o, next_dqs;
  logic                   dqs_oe, next_dqs_oe;

  // storage array; data only, not reset
  logic [31:0]            mem [0:(1 << `LPB_MEM_AW) - 1];

  // every pin crosses two flops before use
  lpb_sync #(.W(SW)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_d       ({bus.ck, bus.cke, bus.cs_n, bus.ca, bus.dm, bus.dq, bus.dqs}),
    .o_q       (pin_s)
  );

  assign {ck_s, cke_s, cs_n_s, ca_s, dm_s, dq_s, dqs_s} = pin_s;
  assign ck_rise = ck_s & ~ck_p;
  assign ck_fall = ~ck_s & ck_p;

  // word address inside a burst: wraps within the four-word group
  function automatic logic [8:0] word_addr(input logic [8:0] b, input logic [1:0] k);
    word_addr = {b[8:2], 2'(b[1:0] + k)};
  endfunction

  // command decode and data sequencing
  always_comb begin
    next_state     = state;
    next_ck_p      = ck_s;
    next_dqs_p     = dqs_s;
    next_cmd       = cmd;
    next_acc_bank  = acc_bank;
    next_row_hi    = row_hi;
    next_open_row  = open_row;
    next_bank_open = bank_open;
    next_base      = base;
    next_rd_word   = rd_word;
    next_beat      = beat;
    next_lane_beat = lane_beat;
    next_wbuf      = wbuf;
    next_wmask     = wmask;
    next_commit    = 1'b0;
    next_dq        = dq_o;
    next_dq_oe     = dq_oe;
    next_dqs       = dqs_o;
    next_dqs_oe    = dqs_oe;
    case (state)
      DS_PDOWN: begin
        // receivers asleep, drivers off
        next_dq_oe  = 1'b0;
        next_dqs_oe = 1'b0;
        if (ck_rise && cke_s) begin
          next_state = DS_IDLE;
        end
      end
      DS_IDLE: begin
        if (ck_rise) begin
          if (!cke_s) begin
            next_state = DS_PDOWN;
          end else if (!cs_n_s && ca_s[`LPB_CMD_LSB +: `LPB_CMD_W] != `LPB_CMD_NOP) begin
            // rise half: code, bank, high row bits; deselect is ignored
            next_cmd      = ca_s[`LPB_CMD_LSB +: `LPB_CMD_W];
            next_acc_bank = ca_s[`LPB_BANK_LSB +: `LPB_BANK_W];
            next_row_hi   = ca_s[`LPB_ROWHI_LSB +: `LPB_ROWHI_W];
            next_state    = DS_CMD;
          end
        end
      end
      DS_CMD: begin
        // fall half completes the one-cycle command
        if (ck_fall) begin
          next_state = DS_IDLE;
          case (cmd)
            `LPB_CMD_ACT: begin
              next_open_row[acc_bank]  = {row_hi, ca_s};
              next_bank_open[acc_bank] = 1'b1;
            end
            `LPB_CMD_PRE: begin
              next_bank_open[acc_bank] = 1'b0;
            end
            `LPB_CMD_RD, `LPB_CMD_WR: begin
              // access to a closed bank is dropped; lowest column bit is zero
              if (bank_open[acc_bank]) begin
                next_base = {acc_bank, open_row[acc_bank][`LPB_MEM_ROW_W-1:0], ca_s[2:0], 1'b0};
                if (cmd == `LPB_CMD_RD) begin
                  for (int k = 0; k < `LPB_BL; k++) begin
                    next_rd_word[k*32 +: 32] = mem[word_addr(next_base, 2'(k))];
                  end
                  next_beat  = '0;
                  next_state = DS_READ;
                end else begin
                  next_lane_beat = '0;
                  next_wmask     = '0;
                  next_state     = DS_WRITE;
                end
              end
            end
            default: begin
              next_state = DS_IDLE;
            end
          endcase
        end
      end
      DS_READ: begin
        // one beat per link clock edge, strobe toggles with the data
        if (ck_rise || ck_fall) begin
          if (beat == 3'(`LPB_BL)) begin
            next_dq_oe  = 1'b0;
            next_dqs_oe = 1'b0;
            next_state  = DS_IDLE;
          end else begin
            next_dq     = rd_word[beat*32 +: 32];
            next_dq_oe  = 1'b1;
            next_dqs    = {4{~beat[0]}};
            next_dqs_oe = 1'b1;
            next_beat   = beat + 3'h1;
          end
        end
      end
      DS_WRITE: begin
        // each lane takes its byte on its own strobe edge
        for (int l = 0; l < `LPB_LANES; l++) begin
          if ((dqs_s[l] ^ dqs_p[l]) && lane_beat[l] != 3'(`LPB_BL)) begin
            next_wbuf[lane_beat[l][1:0]][l*8 +: 8] = dq_s[l*8 +: 8];
            next_wmask[lane_beat[l][1:0]][l]       = dm_s[l];
            next_lane_beat[l]                      = lane_beat[l] + 3'h1;
          end
        end
        if (lane_beat == {4{3'(`LPB_BL)}}) begin
          next_commit = 1'b1;
          next_state  = DS_IDLE;
        end
      end
      default: begin
        next_state = DS_PDOWN;
      end
    endcase
  end

  // control registers; device starts powered down until clock enable rises
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state     <= DS_PDOWN;
      ck_p      <= 1'b0;
      dqs_p     <= '0;
      cmd       <= `LPB_CMD_NOP;
      acc_bank  <= '0;
      row_hi    <= '0;
      open_row  <= '0;
      bank_open <= '0;
      base      <= '0;
      rd_word   <= '0;
      beat      <= '0;
      lane_beat <= '0;
      wbuf      <= '0;
      wmask     <= '0;
      commit    <= 1'b0;
      dq_o      <= '0;
      dq_oe     <= 1'b0;
      dqs_o     <= '0;
      dqs_oe    <= 1'b0;
    end else begin
      state     <= next_state;
      ck_p      <= next_ck_p;
      dqs_p     <= next_dqs_p;
      cmd       <= next_cmd;
      acc_bank  <= next_acc_bank;
      row_hi    <= next_row_hi;
      open_row  <= next_open_row;
      bank_open <= next_bank_open;
      base      <= next_base;
      rd_word   <= next_rd_word;
      beat      <= next_beat;
      lane_beat <= next_lane_beat;
      wbuf      <= next_wbuf;
      wmask     <= next_wmask;
      commit    <= next_commit;
      dq_o      <= next_dq;
      dq_oe     <= next_dq_oe;
      dqs_o     <= next_dqs;
      dqs_oe    <= next_dqs_oe;
    end
  end

  // whole burst lands in one core write; masked bytes keep old contents
  always_ff @(posedge i_clk_sys) begin
    if (commit) begin
      for (int k = 0; k < `LPB_BL; k++) begin
        for (int l = 0; l < `LPB_LANES; l++) begin
          if (!wmask[k][l]) begin
            mem[word_addr(base, 2'(k))][l*8 +: 8] <= wbuf[k][l*8 +: 8];
          end
        end
      end
    end
  end

  assign bus.d_dq_o   = dq_o;
  assign bus.d_dq_oe  = dq_oe;
  assign bus.d_dqs_o  = dqs_o;
  assign bus.d_dqs_oe = dqs_oe;
  assign o_power_down = (state == DS_PDOWN);
  assign o_bank_open  = bank_open;
endmodule // lpb_dev
`default_nettype wire

// ==== core/lpb_host.sv ====
// memory controller end: link clock divider, command issue, burst data
`timescale 1ns/100ps
`default_nettype none
`include "lpb_params.svh"
module lpb_host (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  lpb_if.host                    bus,
  input  wire logic              i_cke,
  input  wire logic              i_req,
  input  wire lpb_pkg::lpb_cmd_t i_op,
  input  wire logic [2:0]        i_bank,
  input  wire logic [13:0]       i_row,
  input  wire logic [8:0]        i_col,
  input  wire logic [127:0]      i_wdata,
  input  wire logic [15:0]       i_wmask,
  output logic                   o_ready,
  output logic [127:0]           o_rdata,
  output logic                   o_rvalid
);
  import lpb_pkg::*;

  logic [35:0]            rd_s;                 // synchronised data and strobes
  logic [31:0]            dq_s;
  logic [3:0]             dqs_s;
  lpb_host_state_t        state, next_state;
  logic [`LPB_PH_W-1:0]   ph, next_ph;          // position in link clock period
  logic                   ck, next_ck;
  logic                   cke, next_cke;
  logic                   cs_n, next_cs_n;
  logic [9:0]             ca, next_ca;
  logic [3:0]             dm, next_dm;
  logic [31:0]            dq, next_dq;
  logic                   dq_oe, next_dq_oe;
  logic [3:0]             dqs, next_dqs;
  logic                   dqs_oe, next_dqs_oe;
  lpb_cmd_t               op, next_op;
  logic [13:0]            row, next_row;
  logic [8:0]             col, next_col;
  logic [127:0]           wdata, next_wdata;
  logic [15:0]            wmask, next_wmask;
  logic [2:0]             cnt, next_cnt;        // beat counter
  logic                   dqs_p, next_dqs_p;
  logic [127:0]           next_rdata;
  logic                   next_rvalid;

  // read data returns from the device domain
  lpb_sync #(.W(36)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_d       ({bus.dq, bus.dqs}),
    .o_q       (rd_s)
  );
  assign {dq_s, dqs_s} = rd_s;

  // commands start only while the link is awake and staying awake
  assign o_ready = (state == HS_IDLE) && (ph == `LPB_PH_RISE_SET) && cke && i_cke;

  // divider, command slots and data beats
  always_comb begin
    next_state  = state;
    next_ph     = (ph == `LPB_PH_W'(`LPB_CK_DIV - 1)) ? '0 : ph + 1'b1;
    next_ck     = (next_ph < `LPB_PH_W'(`LPB_CK_HALF));
    next_cke    = cke;
    next_cs_n   = cs_n;
    next_ca     = ca;
    next_dm     = dm;
    next_dq     = dq;
    next_dq_oe  = dq_oe;
    next_dqs    = dqs;
    next_dqs_oe = dqs_oe;
    next_op     = op;
    next_row    = row;
    next_col    = col;
    next_wdata  = wdata;
    next_wmask  = wmask;
    next_cnt    = cnt;
    next_dqs_p  = dqs_s[0];
    next_rdata  = o_rdata;
    next_rvalid = 1'b0;
    // rise-half slot: deselect unless a new command is taken
    if (ph == `LPB_PH_RISE_SET) begin
      next_cs_n = 1'b1;
      next_ca   = '0;
    end
    case (state)
      HS_IDLE: begin
        if (ph == `LPB_PH_RISE_SET) begin
          next_cke = i_cke;
          if (i_req && o_ready) begin
            next_cs_n  = 1'b0;
            next_ca    = {i_row[13:10], i_bank, i_op};
            next_op    = i_op;
            next_row   = i_row;
            next_col   = i_col;
            next_wdata = i_wdata;
            next_wmask = i_wmask;
            next_state = HS_CMD;
          end
        end
      end
      HS_CMD: begin
        // fall-half slot: row low bits or column bits 8..1
        if (ph == `LPB_PH_FALL_SET) begin
          next_ca  = (op == `LPB_CMD_ACT) ? row[9:0] : {2'b00, col[8:1]};
          next_cnt = '0;
          if (op == `LPB_CMD_WR) begin
            next_state = HS_WDATA;
          end else if (op == `LPB_CMD_RD) begin
            next_state = HS_RDATA;
          end else begin
            next_state = HS_IDLE;
          end
        end
      end
      HS_WDATA: begin
        // data changes on link clock edges, strobe in the middle of each beat
        if (ph == `LPB_PH_DQ_A || (ph == `LPB_PH_DQ_B && cnt != 3'h0)) begin
          if (cnt == 3'(`LPB_BL)) begin
            next_dq_oe  = 1'b0;
            next_dqs_oe = 1'b0;
            next_dm     = '0;
            next_state  = HS_IDLE;
          end else begin
            next_dq     = wdata[cnt*32 +: 32];
            next_dm     = wmask[cnt*4 +: 4];
            next_dq_oe  = 1'b1;
            next_dqs_oe = 1'b1;
          end
        end else if ((ph == `LPB_PH_DQS_A || ph == `LPB_PH_DQS_B) && dqs_oe && cnt != 3'(`LPB_BL)) begin
          next_dqs = {4{~cnt[0]}};
          next_cnt = cnt + 3'h1;
        end
      end
      HS_RDATA: begin
        // take each beat on a strobe edge from the device
        if (dqs_s[0] ^ dqs_p) begin
          next_rdata[cnt*32 +: 32] = dq_s;
          next_cnt                 = cnt + 3'h1;
          if (cnt == 3'(`LPB_BL - 1)) begin
            next_rvalid = 1'b1;
            next_state  = HS_IDLE;
          end
        end
      end
      default: begin
        next_state = HS_IDLE;
      end
    endcase
  end

  // clock enable held low from reset, as power-up asks
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state    <= HS_IDLE;
      ph       <= `LPB_PH_W'(`LPB_CK_DIV - 1); // first edge after reset starts a full high phase
      ck       <= 1'b0;
      cke      <= 1'b0;
      cs_n     <= 1'b1;
      ca       <= '0;
      dm       <= '0;
      dq       <= '0;
      dq_oe    <= 1'b0;
      dqs      <= '0;
      dqs_oe   <= 1'b0;
      op       <= `LPB_CMD_NOP;
      row      <= '0;
      col      <= '0;
      wdata    <= '0;
      wmask    <= '0;
      cnt      <= '0;
      dqs_p    <= 1'b0;
      o_rdata  <= '0;
      o_rvalid <= 1'b0;
    end else begin
      state    <= next_state;
      ph       <= next_ph;
      ck       <= next_ck;
      cke      <= next_cke;
      cs_n     <= next_cs_n;
      ca       <= next_ca;
      dm       <= next_dm;
      dq       <= next_dq;
      dq_oe    <= next_dq_oe;
      dqs      <= next_dqs;
      dqs_oe   <= next_dqs_oe;
      op       <= next_op;
      row      <= next_row;
      col      <= next_col;
      wdata    <= next_wdata;
      wmask    <= next_wmask;
      cnt      <= next_cnt;
      dqs_p    <= next_dqs_p;
      o_rdata  <= next_rdata;
      o_rvalid <= next_rvalid;
    end
  end

  assign bus.ck       = ck;
  assign bus.cke      = cke;
  assign bus.cs_n     = cs_n;
  assign bus.ca       = ca;
  assign bus.dm       = dm;
  assign bus.h_dq_o   = dq;
  assign bus.h_dq_oe  = dq_oe;
  assign bus.h_dqs_o  = dqs;
  assign bus.h_dqs_oe = dqs_oe;
endmodule // lpb_host
`default_nettype wire

// ==== tb/lpb_link_checker.sv ====
// concurrent checks on the wires between controller and device ends
`timescale 1ns/100ps
`default_nettype none
module lpb_link_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic        ck,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic [9:0]  ca,
  input wire logic [31:0] h_dq_o,
  input wire logic        h_dq_oe,
  input wire logic [3:0]  h_dqs_o,
  input wire logic        h_dqs_oe,
  input wire logic [31:0] d_dq_o,
  input wire logic        d_dq_oe,
  input wire logic [3:0]  d_dqs_o,
  input wire logic        d_dqs_oe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // a read burst is four beats of four sys cycles, split to keep repeats short
  sequence s_drive8; d_dq_oe [*8]; endsequence
  sequence s_high4; ck [*4]; endsequence
  one_driver_a: assert property (!(h_dq_oe && d_dq_oe)) else $error("both ends drive data");
  ca_off_edge_a: assert property ($changed(ca) |-> $stable(ck)) else $error("ca moved at a ck edge");
  sel_low_ck_a: assert property ($changed(cs_n) || $changed(cke) |-> !ck)
    else $error("select or enable moved while ck high");
  ck_high4_a: assert property ($rose(ck) |-> s_high4 ##1 !ck) else $error("ck high phase wrong");
  cmd_len_a: assert property ($fell(cs_n) |-> !cs_n [*8]) else $error("command shorter than a ck cycle");
  pd_quiet_a: assert property (!cke && $past(!cke) |-> !d_dq_oe && !d_dqs_oe)
    else $error("device drives while disabled");
  wr_centre_a: assert property (h_dqs_oe && $past(h_dqs_oe) && $changed(h_dqs_o) |-> $stable(h_dq_o))
    else $error("write strobe not centred");
  rd_align_a: assert property (d_dq_oe && $past(d_dq_oe) && $changed(d_dq_o) |-> $changed(d_dqs_o))
    else $error("read strobe not aligned");
  rd_burst_a: assert property ($rose(d_dq_oe) |-> s_drive8 ##1 s_drive8 ##1 !d_dq_oe)
    else $error("read burst length wrong");
endmodule // lpb_link_checker
`default_nettype wire

// ==== tb/tb_top.sv ====
// bench: both link ends joined, bank traffic, power-down and reset
`timescale 1ns/100ps
`default_nettype none
`include "lpb_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import lpb_pkg::*;
  logic           i_clk_sys = 1'b0;
  logic           i_resetn  = 1'b0;
  logic           cke = 1'b0;  // wanted clock enable
  logic           req = 1'b0;
  lpb_cmd_t       op = '0;
  logic [2:0]     bank = '0;
  logic [8:0]     col = '0;
  logic [13:0]    row = 14'h0001;  // row sent with activate
  logic [127:0]   wd = '0;
  logic [15:0]    wm = '0;
  logic [127:0]   rd, d0;
  logic           rdy, rv, pd;
  lpb_bank_mask_t bo;
  int             n_mismatch = 0;
  int             cmp_count = 0;
  // one write mask per bank row
  logic [15:0] msk [8] = '{16'h0000, 16'hFFFF, 16'h000F, 16'hF0F0, 16'h1248, 16'h8421, 16'h5555, 16'hAAAA};
  lpb_if bus ();
  lpb_host i_lpb_host (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .bus(bus.host), .i_cke(cke),
    .i_req(req), .i_op(op), .i_bank(bank), .i_row(row), .i_col(col), .i_wdata(wd),
    .i_wmask(wm), .o_ready(rdy), .o_rdata(rd), .o_rvalid(rv));
  lpb_dev i_lpb_dev (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .bus(bus.dev),
    .o_power_down(pd), .o_bank_open(bo));
  lpb_link_checker i_lpb_link_checker (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .ck(bus.ck),
    .cke(bus.cke), .cs_n(bus.cs_n), .ca(bus.ca), .h_dq_o(bus.h_dq_o), .h_dq_oe(bus.h_dq_oe),
    .h_dqs_o(bus.h_dqs_o), .h_dqs_oe(bus.h_dqs_oe), .d_dq_o(bus.d_dq_o), .d_dq_oe(bus.d_dq_oe),
    .d_dqs_o(bus.d_dqs_o), .d_dqs_oe(bus.d_dqs_oe));
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // masked bytes keep the old value
  function automatic logic [127:0] merge(input logic [127:0] a, input logic [127:0] n, input logic [15:0] m);
    for (int i = 0; i < 16; i++) merge[8*i +: 8] = m[i] ? a[8*i +: 8] : n[8*i +: 8];
  endfunction
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hold the request until a falling-edge look sees ready, so the next rise takes it
  task automatic cmd(input lpb_cmd_t o, input logic [2:0] b, input logic [8:0] c,
                     input logic [127:0] d, input logic [15:0] m);
    int t;
    t = 0;
    @(posedge i_clk_sys);
    op <= o; bank <= b; col <= c; wd <= d; wm <= m; req <= 1'b1;
    do @(negedge i_clk_sys); while (rdy !== 1'b1 && ++t < 300);
    @(posedge i_clk_sys);
    req <= 1'b0;
    if (t >= 300) n_mismatch++;
  endtask
  task automatic rdw(input logic [2:0] b, input logic [8:0] c, input logic [127:0] e);
    int t;
    t = 0;
    cmd(`LPB_CMD_RD, b, c, '0, '0);
    do @(negedge i_clk_sys); while (rv !== 1'b1 && ++t < 80);
    `CHK("rvalid", 1'b1, rv)
    `CHK("rdata", e, rd)
  endtask
  task automatic wait_pd(input logic v);
    int t;
    t = 0;
    do @(negedge i_clk_sys); while (pd !== v && ++t < 80);
    `CHK("pdown", v, pd)
  endtask
  // watchdog: the sequence needs well under 3000 cycles
  initial begin
    #(20000 * 40);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    cke <= 1'b1;
    @(negedge i_clk_sys);
    `CHK("pdown", 1'b1, pd)
    for (int b = 0; b < 8; b++) begin
      d0 = {32{1'b0, b[2:0]}};
      cmd(`LPB_CMD_ACT, b[2:0], '0, '0, '0);
      cmd(`LPB_CMD_WR, b[2:0], '0, d0, '0);
      cmd(`LPB_CMD_WR, b[2:0], '0, ~d0, msk[b]);
    end
    @(negedge i_clk_sys);
    `CHK("open", 8'hFF, bo)
    for (int b = 0; b < 8; b++) begin
      d0 = {32{1'b0, b[2:0]}};
      rdw(b[2:0], '0, merge(d0, ~d0, msk[b]));
    end
    $display("bank rows done");
    // lowest column bit is never sent, so column 1 reads column 0
    rdw(3'h2, 9'h001, merge({32{4'h2}}, ~{32{4'h2}}, msk[2]));
    cmd(`LPB_CMD_PRE, 3'h5, '0, '0, '0);
    // the fall half reaches the device a full link period after the take
    repeat (12) @(negedge i_clk_sys);
    `CHK("open", 8'hDF, bo)
    $display("column and precharge done");
    @(posedge i_clk_sys);
    cke <= 1'b0;
    wait_pd(1'b1);
    `CHK("dq_oe", 1'b0, bus.d_dq_oe)
    @(posedge i_clk_sys);
    cke <= 1'b1;
    wait_pd(1'b0);
    rdw(3'h0, '0, merge({32{4'h0}}, ~{32{4'h0}}, msk[0]));
    $display("power down done");
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    `CHK("open", 8'h00, bo)
    `CHK("pdown", 1'b1, pd)
    @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    row <= 14'h0002;
    cmd(`LPB_CMD_NOP, 3'h3, '0, '0, '0);
    repeat (12) @(negedge i_clk_sys);
    `CHK("open", 8'h00, bo)
    cmd(`LPB_CMD_ACT, 3'h3, '0, '0, '0);
    repeat (12) @(negedge i_clk_sys);
    `CHK("open", 8'h08, bo)
    // a second row of the same bank keeps its own data; storage survives reset
    cmd(`LPB_CMD_WR, 3'h3, '0, {4{32'h1234_5678}}, '0);
    rdw(3'h3, '0, {4{32'h1234_5678}});
    @(posedge i_clk_sys);
    row <= 14'h0001;
    cmd(`LPB_CMD_ACT, 3'h3, '0, '0, '0);
    rdw(3'h3, '0, merge({32{4'h3}}, ~{32{4'h3}}, msk[3]));
    $display("reset done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
